// ===== hdl/wake_pkg.sv
// Shared types and constants for the wake and interrupt-enable block
package wake_pkg;

  // Instruction opcodes seen from the CPU core, one-hot
  typedef enum logic [5:0] {
    OP_PORT_COND   = 6'h01,  // Loads the port switch enables
    OP_HALT_EN     = 6'h02,  // Loads the halt release enables
    OP_INT_EN      = 6'h04,  // Loads the interrupt enables
    OP_STOP_EN     = 6'h08,  // Loads the stop release enables
    OP_CLEAR_REQ   = 6'h10,  // Clears release request flags
    OP_STATUS_READ = 6'h20   // Copies the fourth status register out
  } instr_op_t;

  // One instruction from the CPU core, valid for one cycle
  typedef struct packed {
    logic       valid;
    instr_op_t  op;
    logic [7:0] data;
  } instr_t;

  // One-cycle event pulses from the neighbouring blocks
  typedef struct packed {
    logic timer1_underflow;
    logic timer2_underflow;
    logic prediv_overflow;
    logic counter_finish;
    logic counter_overflow;
    logic counter_start;
  } events_t;

  // Interrupt acceptance from the CPU core
  typedef struct packed {
    logic       valid;
    logic [2:0] num;
  } int_ack_t;

  // Bit positions in the instruction data
  localparam int SEF_PORT2_BIT  = 3;  // Second port switch enable
  localparam int SEF_PORT1_BIT  = 4;  // First port switch enable
  localparam int STOP_PORT2_BIT = 3;  // Second port stop enable
  localparam int STOP_PORT1_BIT = 4;  // First port stop enable
  localparam int STOP_PIN_BIT   = 5;  // Interrupt pin stop enable
  localparam int STOP_KEY_BIT   = 7;  // Key input stop enable

  // Release request numbering, also the interrupt numbering
  localparam int REQ_PORT       = 0;
  localparam int REQ_TIMER1     = 1;
  localparam int REQ_PIN        = 2;
  localparam int REQ_PREDIV     = 3;
  localparam int REQ_TIMER2     = 4;
  localparam int REQ_KEY        = 5;
  localparam int REQ_COUNTER    = 6;
  localparam int NUM_REQ        = 7;

  // Layout of the synchronised pin vector
  localparam int PIN_PORT1_LSB  = 0;
  localparam int PIN_PORT2_LSB  = 4;
  localparam int PIN_PORT3_LSB  = 8;
  localparam int PIN_INT        = 12;
  localparam int NUM_PINS       = 13;

  // Fourth status register field positions and reserved value
  localparam int STS_CLK_BIT    = 0;
  localparam int STS_WDT_BIT    = 1;
  localparam int STS_OVF_BIT    = 2;
  localparam int STS_RSV_BIT    = 3;
  localparam logic STS_RSV_VAL  = 1'b0;

  // Reset values of the enable registers
  localparam logic [1:0] SEF_RST = 2'h0;
  localparam logic [5:0] HEF_RST = 6'h00;
  localparam logic [6:0] INT_EN_RST = 7'h00;

endpackage

// ===== hdl/wake_release_interrupt_enables.sv
// Wake sources, release requests and interrupt enables of the 4-bit core
`timescale 1ns/1ps

// Operation
// RL1: Counter overflow sets flag; counter start clears it
// RL2: Status read copies clock, watchdog, overflow bits
// RL3: First port high in stop sets wake
// RL4: Second port high in stop sets wake
// RL5: Latched key high in stop sets wake
// RL6: Pin change in stop sets wake
// RL7: Stop refused unless designated ports input-low
// RL8: Software clears stop requests before stop
// RL9: Stop-enable instruction loads stop release enables
// RL10: Port-condition instruction loads two switch enables
// RL11: Enabled port change releases halt, sets start
// RL12: Outside holds unchanged port inputs at zero
// RL13: Both enables plus port high release stop; the code releases stop with the stop enable alone
// RL14: Stop release goes halt; high must persist
// RL15: Port start sets request; enable raises interrupt
// RL16: Accepted port interrupt blocks until port-condition
// RL17: Halt enable instruction loads six release enables
// RL18: Pin stop release needs both enables
// RL19: Key stop release needs both enables
// RL20: Interrupt enable instruction loads seven enables
// RL21: Accepting interrupt clears its request and enable
// RL22: Service routine re-arms wanted interrupt enables
// RL23: Halt refused while release signal pending
// RL24: Port-condition instruction clears port start flags
// RL25: Lowest-numbered enabled request is served first
module wake_release_interrupt_enables
  import wake_pkg::*;
(
  input  wire logic       I_CLK,
  input  wire logic       I_SYS_RST,
  input  wire instr_t     i_instr,
  input  wire events_t    i_events,
  input  wire int_ack_t   i_int_ack,
  input  wire logic [3:0] I_PORT1_PINS,
  input  wire logic [3:0] I_PORT1_INPUT_MODE,
  input  wire logic [3:0] I_PORT2_PINS,
  input  wire logic [3:0] I_PORT2_INPUT_MODE,
  input  wire logic [3:0] I_PORT3_PINS,
  input  wire logic [3:0] I_PORT3_INPUT_MODE,
  input  wire logic       I_INT_PIN,
  input  wire logic [3:0] I_KEY_LATCH,
  input  wire logic       I_STOP_MODE,
  input  wire logic       I_CLOCK_SOURCE_SEL,
  input  wire logic       I_WATCHDOG_EN,
  output logic            o_int_req,
  output logic [2:0]      o_int_num,
  output logic            o_halt_block,
  output logic            o_stop_allowed,
  output logic            o_stop_release,
  output logic [1:0]      o_start_flags,
  output logic [6:0]      o_release_req,
  output logic [3:0]      o_status_data
);

  // Whole state of the block, registered in one process
  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0] filt;
    logic [1:0]          sef;
    logic [5:0]          hef;
    logic [6:0]          int_en;
    logic                stop_en_port1;
    logic                stop_en_port2;
    logic                stop_en_pin;
    logic                stop_en_key;
    logic [6:0]          hrf;
    logic                start_port1;
    logic                start_port2;
    logic                port1_stop_req;
    logic                port2_stop_req;
    logic                key_stop_req;
    logic                stop_wake;
    logic                ovf;
    logic                port_int_block;
    logic                int_req;
    logic [2:0]          int_num;
    logic                halt_block;
    logic                stop_allowed;
    logic [3:0]          status;
  } state_t;

  state_t st;
  state_t next_st;

  // OR of the pins that are in input mode
  function automatic logic or_inputs(input logic [3:0] pins,
                                     input logic [3:0] mode);
    or_inputs = |(pins & mode);
  endfunction

  // True when every pin is an input held low
  function automatic logic idle_inputs(input logic [3:0] pins,
                                       input logic [3:0] mode);
    idle_inputs = (&mode) && !(|pins);
  endfunction

  // Decoded one-hot mask of a request number
  function automatic logic [6:0] req_mask(input logic [2:0] num);
    req_mask = 7'h00;
    if (num < 3'h7)
    begin
      req_mask[num] = 1'b1;
    end
  endfunction

  logic [NUM_PINS-1:0] pins_raw;
  logic [NUM_PINS-1:0] agree;
  logic [NUM_PINS-1:0] changed;
  logic [3:0]          port1_lvl;
  logic [3:0]          port2_lvl;
  logic [3:0]          port3_lvl;
  logic                port1_or;
  logic                port2_or;
  logic                key_or;
  logic                port1_chg;
  logic                port2_chg;
  logic                pin_chg;
  logic                set_start1;
  logic                set_start2;
  logic [6:0]          ack_clear;
  logic [6:0]          plc_clear;
  logic [6:0]          req_set;
  logic [6:0]          pending;
  logic                found;
  logic [2:0]          first_num;

  // External pins gathered into one vector for the synchroniser
  assign pins_raw = {I_INT_PIN, I_PORT3_PINS, I_PORT2_PINS, I_PORT1_PINS};

  // Next-state logic for the whole block
  always_comb
  begin
    next_st = st;

    // Three-stage synchroniser; a level counts once stages 2 and 3 agree
    next_st.sync1 = pins_raw;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    agree         = ~(st.sync2 ^ st.sync3);
    changed       = agree & (st.sync3 ^ st.filt);
    next_st.filt  = (st.filt & ~agree) | (st.sync3 & agree);

    // Settled pin levels; the bouncing filter itself lives elsewhere
    port1_lvl = st.filt[PIN_PORT1_LSB +: 4];
    port2_lvl = st.filt[PIN_PORT2_LSB +: 4];
    port3_lvl = st.filt[PIN_PORT3_LSB +: 4];
    port1_or  = or_inputs(port1_lvl, I_PORT1_INPUT_MODE);
    port2_or  = or_inputs(port2_lvl, I_PORT2_INPUT_MODE);
    key_or    = |I_KEY_LATCH;  // Latch runs on this clock, no sync needed
    // Any toggle of an input-mode pin is a change; the outside keeps
    // idle pins at zero so one pin alone makes the event
    port1_chg = |(changed[PIN_PORT1_LSB +: 4] & I_PORT1_INPUT_MODE); // see RL12
    port2_chg = |(changed[PIN_PORT2_LSB +: 4] & I_PORT2_INPUT_MODE); // see RL12
    pin_chg   = changed[PIN_INT];

    plc_clear  = 7'h00;
    ack_clear  = 7'h00;
    req_set    = 7'h00;
    set_start1 = 1'b0;
    set_start2 = 1'b0;

    // Instruction decode; a garbled opcode is ignored
    if (i_instr.valid)
    begin
      unique case (i_instr.op)
        OP_PORT_COND:
        begin
          next_st.sef[1]         = i_instr.data[SEF_PORT1_BIT]; // see RL10
          next_st.sef[0]         = i_instr.data[SEF_PORT2_BIT]; // see RL10
          next_st.start_port1    = 1'b0;  // see RL24
          next_st.start_port2    = 1'b0;  // see RL24
          next_st.port_int_block = 1'b0;  // see RL16
        end
        OP_HALT_EN:
        begin
          next_st.hef = i_instr.data[6:1];  // see RL17
        end
        OP_INT_EN:
        begin
          next_st.int_en = i_instr.data[6:0];  // see RL20
        end
        OP_STOP_EN:
        begin
          next_st.stop_en_port1 = i_instr.data[STOP_PORT1_BIT]; // see RL9
          next_st.stop_en_port2 = i_instr.data[STOP_PORT2_BIT]; // see RL9
          next_st.stop_en_pin   = i_instr.data[STOP_PIN_BIT];   // see RL9
          next_st.stop_en_key   = i_instr.data[STOP_KEY_BIT];   // see RL9
        end
        OP_CLEAR_REQ:
        begin
          plc_clear = i_instr.data[6:0];
        end
        OP_STATUS_READ:
        begin
          // Reserved bit reads as a constant
          next_st.status[STS_CLK_BIT] = I_CLOCK_SOURCE_SEL;  // see RL2
          next_st.status[STS_WDT_BIT] = I_WATCHDOG_EN;       // see RL2
          next_st.status[STS_OVF_BIT] = st.ovf;              // see RL2
          next_st.status[STS_RSV_BIT] = STS_RSV_VAL;         // see RL2
        end
        default:
        begin
          plc_clear = 7'h00;
        end
      endcase
    end

    // Stop requests are cleared with their matching release requests,
    // which software does before stopping
    if (plc_clear[REQ_PORT])
    begin
      next_st.port1_stop_req = 1'b0;  // see RL8
      next_st.port2_stop_req = 1'b0;  // see RL8
    end
    if (plc_clear[REQ_KEY])
    begin
      next_st.key_stop_req = 1'b0;  // see RL8
    end

    // Interrupt acceptance drops its request and its own enable
    if (i_int_ack.valid)
    begin
      ack_clear = req_mask(i_int_ack.num);  // see RL21
      // A same-cycle enable write from software wins over the clear
      if (!(i_instr.valid && i_instr.op == OP_INT_EN))
      begin
        next_st.int_en = next_st.int_en & ~ack_clear;  // see RL21
      end
      if (i_int_ack.num == 3'(REQ_PORT))
      begin
        next_st.port_int_block = 1'b1;  // see RL16
      end
    end

    // Halt-mode port wake: a change on an enabled port
    if (!I_STOP_MODE)
    begin
      set_start1 = st.sef[1] && port1_chg;  // see RL11
      set_start2 = st.sef[0] && port2_chg;  // see RL11
    end
    else
    begin
      // Stop-mode port start flag needs the switch and stop enables and a
      // high level; the CPU drops back to halt and then to stop again
      // if the level has gone before the debouncer saw it
      set_start1 = st.sef[1] && st.stop_en_port1
                   && port1_or;  // see RL13, RL14
      set_start2 = st.sef[0] && st.stop_en_port2
                   && port2_or;  // see RL13, RL14
    end
    if (set_start1)
    begin
      next_st.start_port1 = 1'b1;  // see RL11
    end
    if (set_start2)
    begin
      next_st.start_port2 = 1'b1;  // see RL11
    end

    // Release request sources; a set in the cycle of a clear wins
    req_set[REQ_PORT]    = set_start1 || set_start2;          // see RL15
    req_set[REQ_TIMER1]  = i_events.timer1_underflow;
    req_set[REQ_PIN]     = pin_chg;
    req_set[REQ_PREDIV]  = i_events.prediv_overflow;
    req_set[REQ_TIMER2]  = i_events.timer2_underflow;
    req_set[REQ_KEY]     = key_or;
    req_set[REQ_COUNTER] = i_events.counter_finish;
    next_st.hrf = (st.hrf & ~plc_clear & ~ack_clear) | req_set;

    // Stop release requests while stopped
    if (I_STOP_MODE)
    begin
      if (port1_or)
      begin
        next_st.port1_stop_req = 1'b1;  // see RL3
      end
      if (port2_or)
      begin
        next_st.port2_stop_req = 1'b1;  // see RL4
      end
      if (key_or)
      begin
        next_st.key_stop_req = 1'b1;  // see RL5
      end
      // Wake flag from a port with its stop enable, or from a pin or key with both enables
      if ((port1_or && st.stop_en_port1)                  // see RL3
          || (port2_or && st.stop_en_port2)               // see RL4
          || (key_or && st.stop_en_key && st.hef[4])      // see RL5, RL19
          || (pin_chg && st.stop_en_pin && st.hef[1])     // see RL6, RL18
          || set_start1 || set_start2)
      begin
        next_st.stop_wake = 1'b1;
      end
    end
    else
    begin
      next_st.stop_wake = 1'b0;  // Ends with the stop mode itself
    end

    // Counter overflow flag; overflow wins over a same-cycle start
    if (i_events.counter_start)
    begin
      next_st.ovf = 1'b0;  // see RL1
    end
    if (i_events.counter_overflow)
    begin
      next_st.ovf = 1'b1;  // see RL1
    end

    // Pending interrupts; the port path may be held off after service
    pending    = next_st.hrf & next_st.int_en;
    pending[0] = pending[0] && !next_st.port_int_block;  // see RL16
    found      = 1'b0;
    first_num  = 3'h0;
    for (int n = 0; n < NUM_REQ; n++)
    begin
      if (pending[n] && !found)
      begin
        found     = 1'b1;
        first_num = 3'(n);  // see RL25
      end
    end
    next_st.int_req = found;      // see RL15, RL20
    next_st.int_num = first_num;  // see RL25

    // Any pending halt release signal keeps the core out of halt
    next_st.halt_block = next_st.start_port1 || next_st.start_port2
                         || |(next_st.hrf[6:1] & next_st.hef); // see RL23

    // Stop only with both designated ports as inputs held low
    next_st.stop_allowed = idle_inputs(port1_lvl, I_PORT1_INPUT_MODE)
                           && idle_inputs(port3_lvl,
                                          I_PORT3_INPUT_MODE); // see RL7
  end

  // State register with synchronous reset
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // All outputs come straight from the state register
  assign o_int_req      = st.int_req;
  assign o_int_num      = st.int_num;
  assign o_halt_block   = st.halt_block;
  assign o_stop_allowed = st.stop_allowed;
  assign o_stop_release = st.stop_wake;
  assign o_start_flags  = {st.start_port2, st.start_port1};
  assign o_release_req  = st.hrf;
  assign o_status_data  = st.status;

endmodule

// ===== tb/wake_checker_sva.sv
// Port-level assertions for the wake and interrupt-enable block
`timescale 1ns/1ps
module wake_checker
  import wake_pkg::*;
(
  input wire logic       I_CLK,
  input wire logic       I_SYS_RST,
  input wire instr_t     i_instr,
  input wire events_t    i_events,
  input wire int_ack_t   i_int_ack,
  input wire logic [3:0] I_PORT1_INPUT_MODE,
  input wire logic       I_STOP_MODE,
  input wire logic       I_CLOCK_SOURCE_SEL,
  input wire logic       I_WATCHDOG_EN,
  input wire logic       o_int_req,
  input wire logic [2:0] o_int_num,
  input wire logic       o_halt_block,
  input wire logic       o_stop_allowed,
  input wire logic       o_stop_release,
  input wire logic [1:0] o_start_flags,
  input wire logic [6:0] o_release_req,
  input wire logic [3:0] o_status_data
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  logic rd;
  // Status read strobe shared by the status checks
  assign rd = i_instr.valid && (i_instr.op == OP_STATUS_READ);
  a_timer_sets_req: assert property (
    i_events.timer1_underflow |=> o_release_req[REQ_TIMER1])
    else $error("timer request not raised");
  a_ack_clears_req: assert property (
    i_int_ack.valid && i_int_ack.num == 3'h3 && !i_events.prediv_overflow
    |=> !o_release_req[REQ_PREDIV]) else $error("accepted request kept");
  a_int_has_req: assert property (
    o_int_req |-> o_release_req[o_int_num])
    else $error("interrupt number without request");
  a_ovf_read_one: assert property (
    i_events.counter_overflow ##1 (rd && !i_events.counter_start)
    |=> o_status_data[STS_OVF_BIT]) else $error("overflow flag lost");
  a_status_fields: assert property (
    rd |=> o_status_data[STS_CLK_BIT] == $past(I_CLOCK_SOURCE_SEL)
    && o_status_data[STS_WDT_BIT] == $past(I_WATCHDOG_EN)
    && o_status_data[STS_RSV_BIT] == STS_RSV_VAL) else $error("status bad");
  a_status_holds: assert property (
    !rd |=> $stable(o_status_data)) else $error("status moved unread");
  a_wake_needs_stop: assert property (
    !I_STOP_MODE |=> !o_stop_release) else $error("wake flag outside stop");
  a_start_blocks_halt: assert property (
    o_start_flags != 2'h0 |-> o_halt_block) else $error("halt not blocked");
  a_mode_blocks_stop: assert property (
    (I_PORT1_INPUT_MODE != 4'hf) [*3] |-> !o_stop_allowed)
    else $error("stop allowed with output pin");
  c_int: cover property (o_int_req);
  c_wake: cover property (o_stop_release);
  c_ack0: cover property (i_int_ack.valid && i_int_ack.num == 3'h0);
endmodule

bind wake_release_interrupt_enables wake_checker chk (
  .I_CLK, .I_SYS_RST, .i_instr, .i_events, .i_int_ack,
  .I_PORT1_INPUT_MODE, .I_STOP_MODE, .I_CLOCK_SOURCE_SEL, .I_WATCHDOG_EN,
  .o_int_req, .o_int_num, .o_halt_block, .o_stop_allowed, .o_stop_release,
  .o_start_flags, .o_release_req, .o_status_data);

// ===== tb/cpu_core_model.sv
// CPU core stand-in: issues instructions and accepts interrupts
`timescale 1ns/1ps
module cpu_core_model
  import wake_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_int_req,
  input  wire logic [2:0] i_int_num,
  input  wire logic       i_ack_on,
  input  wire logic [3:0] i_ack_delay,
  output instr_t          o_instr,
  output int_ack_t        o_int_ack
);
  logic [3:0] wait_cnt;
  // Idle bus from time zero
  initial
  begin
    o_instr = '0;
    o_int_ack = '0;
    wait_cnt = 4'h0;
  end
  // One instruction per call, valid for exactly one cycle
  task automatic exec(input instr_op_t op, input logic [7:0] data);
    @(posedge i_clk);
    o_instr <= {1'b1, op, data};
    @(posedge i_clk);
    o_instr <= '0;
  endtask
  // Accepts after a chosen delay; skips a cycle after each pulse so the
  // recomputed number is seen, not the stale one
  always @(posedge i_clk)
    if (i_rst || !i_ack_on || o_int_ack.valid || !i_int_req)
    begin
      o_int_ack <= '0;
      wait_cnt <= 4'h0;
    end
    else if (wait_cnt >= i_ack_delay)
      o_int_ack <= {1'b1, i_int_num};
    else
      wait_cnt <= wait_cnt + 4'h1;
endmodule

// ===== tb/wake_release_interrupt_enables_tb_top.sv
// Self-checking bench for the wake and interrupt-enable block
`timescale 1ns/1ps
module wake_release_interrupt_enables_tb_top;
  import wake_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, ipin = 1'b0, stop = 1'b0, csel = 1'b0;
  logic       ack_on = 1'b0, track = 1'b1, ireq, hblk, sok, srel;
  logic       wdog = 1'b0;
  logic [3:0] p1 = 4'h0, p2 = 4'h0, p3 = 4'h0, m1 = 4'hf, keys = 4'h0;
  logic [3:0] dly = 4'h0, sts, m_sts;
  logic [2:0] inum;
  logic [1:0] sflg;
  logic [6:0] rreq, m_req, m_int_en, m_hef, msk;
  logic       m_blk, m_ovf;
  logic [31:0] lfsr = 32'h50e2;
  int         fails = 0, total_checks = 0;
  events_t    ev = '0;
  instr_t     instr;
  int_ack_t   ack;
  instr_op_t  ops [7] = '{OP_PORT_COND, OP_HALT_EN, OP_INT_EN, OP_STOP_EN,
                          OP_CLEAR_REQ, OP_STATUS_READ, instr_op_t'(6'h03)};

  wake_release_interrupt_enables dut (.I_CLK(clk), .I_SYS_RST(rst),
    .i_instr(instr), .i_events(ev), .i_int_ack(ack), .I_PORT1_PINS(p1),
    .I_PORT1_INPUT_MODE(m1), .I_PORT2_PINS(p2), .I_PORT2_INPUT_MODE(4'hf),
    .I_PORT3_PINS(p3), .I_PORT3_INPUT_MODE(4'hf), .I_INT_PIN(ipin),
    .I_KEY_LATCH(keys), .I_STOP_MODE(stop), .I_CLOCK_SOURCE_SEL(csel),
    .I_WATCHDOG_EN(wdog), .o_int_req(ireq), .o_int_num(inum),
    .o_halt_block(hblk), .o_stop_allowed(sok), .o_stop_release(srel),
    .o_start_flags(sflg), .o_release_req(rreq), .o_status_data(sts));
  cpu_core_model cpu (.i_clk(clk), .i_rst(rst), .i_int_req(ireq),
    .i_int_num(inum), .i_ack_on(ack_on), .i_ack_delay(dly),
    .o_instr(instr), .o_int_ack(ack));

  // 250 MHz clock
  initial
    forever #2 clk = ~clk;

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [2:0] lowest(input logic [6:0] v);
    lowest = 3'h0;
    for (int i = 6; i >= 0; i--)
      if (v[i])
        lowest = 3'(i);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded watch of one output; a missed expected rise, or fall of the interrupt request, ends the run
  task automatic await(input int w, input logic want);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 16 && !hit; i++)
    begin
      @(negedge clk);
      hit = (w == 0) ? sflg[0] : (w == 1) ? rreq[0] : (w == 2) ? srel : !ireq;
    end
    check({7'h0, hit}, {7'h0, want});
    if (want && !hit)
      conclude();
  endtask
  task automatic pulse(input events_t e);
    @(posedge clk) ev <= e;
    @(posedge clk) ev <= '0;
  endtask

  // Reference model; clears apply before sets so a new event wins
  always @(posedge clk)
    if (rst)
      {m_req, m_int_en, m_hef, m_blk, m_ovf, m_sts} = '0;
    else
    begin
      if (ack.valid)
      begin
        m_req[ack.num] = 1'b0;
        m_int_en[ack.num] = 1'b0;
        m_blk = m_blk | (ack.num == 3'h0);
      end
      if (instr.valid)
        case (instr.op)
          // A same-cycle acceptance of interrupt 0 wins over the clear
          OP_PORT_COND:   m_blk = ack.valid && ack.num == 3'h0;
          OP_HALT_EN:     m_hef = instr.data[6:0] & 7'h7e;
          OP_INT_EN:      m_int_en = instr.data[6:0];
          OP_CLEAR_REQ:   m_req = m_req & ~instr.data[6:0];
          OP_STATUS_READ: m_sts = {1'b0, m_ovf, wdog, csel};
          default:        ;
        endcase
      if (ev.counter_start)
        m_ovf = 1'b0;
      if (ev.counter_overflow)
        m_ovf = 1'b1;
      m_req = m_req | {ev.counter_finish, 1'b0, ev.timer2_underflow,
                       ev.prediv_overflow, 1'b0, ev.timer1_underflow, 1'b0};
    end

  // Compare at the falling edge, once the design's outputs have settled
  always @(negedge clk)
    if (track && !rst)
    begin
      msk = m_req & m_int_en & {6'h3f, !m_blk};
      check({1'b0, rreq}, {1'b0, m_req});
      check({7'h0, ireq}, {7'h0, |msk});
      if (|msk)
        check({5'h0, inum}, {5'h0, lowest(msk)});
      check({7'h0, hblk}, {7'h0, |(m_req & m_hef)});
      check({4'h0, sts}, {4'h0, m_sts});
    end

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    check({7'h0, sok}, 8'h01);
    @(posedge clk) p3 <= 4'h4;
    repeat (8) @(posedge clk);
    check({7'h0, sok}, 8'h00);
    @(posedge clk) {p3, m1} <= 8'h0d;
    repeat (8) @(posedge clk);
    check({7'h0, sok}, 8'h00);
    @(posedge clk) {m1, csel} <= 5'h1f;
    // Start alone, overflow alone, then both: overflow must win
    for (int k = 1; k < 4; k++)
    begin
      pulse(events_t'(k[5:0]));
      cpu.exec(OP_STATUS_READ, 8'h00);
      @(negedge clk);
      check({4'h0, sts}, {5'h0, k[1], 2'h1});
    end
    // Random traffic with prompt and slow acceptance
    ack_on <= 1'b1;
    fork
      repeat (3000)
      begin
        @(posedge clk);
        ev <= events_t'(6'(rnd() & rnd()));
        {wdog, dly} <= 5'(rnd());
      end
      repeat (900)
        cpu.exec(ops[rnd() % 7], 8'(rnd()));
    join
    @(posedge clk) ev <= '0;
    {ack_on, track, dly} <= 6'h0;
    // Halt-mode port change, interrupt 0 and its inhibit
    cpu.exec(OP_CLEAR_REQ, 8'h7f);
    cpu.exec(OP_INT_EN, 8'h01);
    cpu.exec(OP_PORT_COND, 8'h10);
    @(posedge clk) p1 <= 4'h1;
    await(0, 1'b1);
    repeat (2) @(negedge clk);
    check({6'h0, ireq, rreq[0]}, 8'h03);
    ack_on <= 1'b1;
    await(3, 1'b1);
    ack_on <= 1'b0;
    check({7'h0, rreq[0]}, 8'h00);
    cpu.exec(OP_INT_EN, 8'h01);
    @(posedge clk) p1 <= 4'h0;
    await(1, 1'b1);
    check({7'h0, ireq}, 8'h00);
    cpu.exec(OP_PORT_COND, 8'h00);
    repeat (2) @(negedge clk);
    check({5'h0, sflg, ireq}, 8'h01);
    // Stop wake from the second port
    cpu.exec(OP_CLEAR_REQ, 8'h7f);
    cpu.exec(OP_STOP_EN, 8'h08);
    cpu.exec(OP_PORT_COND, 8'h08);
    @(posedge clk) stop <= 1'b1;
    @(posedge clk) p2 <= 4'h2;
    await(2, 1'b1);
    repeat (2) @(negedge clk);
    check({6'h0, sflg}, 8'h02);
    @(posedge clk) p2 <= 4'h0;
    // Pin then key wake, each without and with its halt enable
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk) stop <= 1'b0;
      cpu.exec(OP_HALT_EN, k[0] ? (k[1] ? 8'h20 : 8'h04) : 8'h00);
      cpu.exec(OP_STOP_EN, 8'ha0);
      cpu.exec(OP_CLEAR_REQ, 8'h7f);
      @(posedge clk) stop <= 1'b1;
      if (k[1])
        @(posedge clk) keys <= 4'h8;
      else
        @(posedge clk) ipin <= !ipin;
      await(2, k[0]);
      check({7'h0, rreq[k[1] ? 5 : 2]}, 8'h01);
      @(posedge clk) keys <= 4'h0;
    end
    conclude();
  end
endmodule
